// >>> rtl/wds_top.sv
// Watchdog supervisor with AXI4-Lite registers and interrupt
//
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "wds_defines.svh"
module wds_top import wds_pkg::*;
#(
   parameter int unsigned ADDR_W = `WDS_ADDR_W
)
(
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write address
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // AXI4-Lite write data and response
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Instruction strobes from the CPU core
   input  wds_instr_s             instr,
   // Reset outputs and interrupt
   output logic                   wd_reset_req,
   output logic                   reset_output_pin_n,
   output logic                   irq
);

   // Word decode shared by the read and write paths
   function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] ofs);
      reg_hit = (addr[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
   endfunction

   // Write channel holding registers
   logic                  aw_have_q;
   logic [ADDR_W-1:0]     awaddr_q;
   logic                  w_have_q;
   logic [31:0]           wdata_q;
   logic [3:0]            wstrb_q;
   logic                  bvalid_q;
   logic [1:0]            bresp_q;
   // Read channel registers
   logic                  rvalid_q;
   logic [31:0]           rdata_q;
   logic [1:0]            rresp_q;
   logic [31:0]           rd_mux;
   logic                  rd_ok;
   // Software-visible settings
   logic                  presc_sel_q;
   logic [7:0]            reload_q;
   logic [`WDS_EV_W-1:0]  int_en_q;
   logic [`WDS_EV_W-1:0]  int_sts_q;
   logic [`WDS_EV_W-1:0]  int_sts_d;
   // Watchdog core
   wds_state_e            state_q;
   wds_state_e            state_d;
   logic                  init_done_q;
   logic [`WDS_CNT_W-1:0] cnt_q;
   logic [`WDS_CNT_W-1:0] cnt_d;
   logic                  rst_req_q;
   logic                  pin_low_q;
   logic                  tick;
   wds_ev_s               ev;

   // Handshakes: one write and one read in flight at most
   wire aw_fire  = s_axi_awvalid && s_axi_awready;
   wire w_fire   = s_axi_wvalid && s_axi_wready;
   wire ar_fire  = s_axi_arvalid && s_axi_arready;
   wire wr_fire  = aw_have_q && w_have_q;
   assign s_axi_awready = !aw_have_q && !bvalid_q;
   assign s_axi_wready  = !w_have_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   // Write decode; read-only registers take writes silently
   wire wr_ctrl   = wr_fire && reg_hit(awaddr_q, `WDS_OFS_CTRL);
   wire wr_clr    = wr_fire && reg_hit(awaddr_q, `WDS_OFS_INT_CLR);
   wire wr_en     = wr_fire && reg_hit(awaddr_q, `WDS_OFS_INT_EN);
   wire wr_mapped = reg_hit(awaddr_q, `WDS_OFS_CTRL)
                 || reg_hit(awaddr_q, `WDS_OFS_COUNT)
                 || reg_hit(awaddr_q, `WDS_OFS_STATE)
                 || reg_hit(awaddr_q, `WDS_OFS_INT_STS)
                 || reg_hit(awaddr_q, `WDS_OFS_INT_CLR)
                 || reg_hit(awaddr_q, `WDS_OFS_INT_EN);
   wire [`WDS_EV_W-1:0] clr_bits = (wr_clr && wstrb_q[0]) ?
                                   wdata_q[`WDS_EV_W-1:0] : '0;

   // Address and data may arrive in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
      end
      else
      begin
         aw_have_q <= wr_fire ? 1'b0 : (aw_have_q || aw_fire);
         w_have_q  <= wr_fire ? 1'b0 : (w_have_q || w_fire);
      end
   end

   // Captured write payload
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awaddr_q <= '0;
         wdata_q  <= '0;
         wstrb_q  <= '0;
      end
      else
      begin
         if (aw_fire)
            awaddr_q <= s_axi_awaddr;
         if (w_fire)
         begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
      end
   end

   // Write response held until taken
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_q <= 1'b0;
         bresp_q  <= `WDS_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_mapped ? `WDS_RESP_OKAY : `WDS_RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_q <= 1'b0;
   end

   // Settings stay writable after end of init; reload applies at the next service, prescaler select and enables at once
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         presc_sel_q <= `WDS_PRESC_RST;
         reload_q    <= `WDS_RELOAD_RST;
         int_en_q    <= '0;
      end
      else
      begin
         if (wr_ctrl && wstrb_q[0])
            presc_sel_q <= wdata_q[`WDS_CTRL_PRESC_BIT];
         if (wr_ctrl && wstrb_q[1])
            reload_q <= wdata_q[`WDS_CTRL_RELOAD_MSB:`WDS_CTRL_RELOAD_LSB];
         if (wr_en && wstrb_q[0])
            int_en_q <= wdata_q[`WDS_EV_W-1:0];
      end
   end

   // Read mux
   always_comb
   begin
      rd_mux = '0;
      rd_ok  = 1'b1;
      if (reg_hit(s_axi_araddr, `WDS_OFS_CTRL))
      begin
         rd_mux[`WDS_CTRL_PRESC_BIT]                      = presc_sel_q;
         rd_mux[`WDS_CTRL_RELOAD_MSB:`WDS_CTRL_RELOAD_LSB] = reload_q;
      end
      else if (reg_hit(s_axi_araddr, `WDS_OFS_COUNT))
         rd_mux[`WDS_CNT_W-1:0] = cnt_q;
      else if (reg_hit(s_axi_araddr, `WDS_OFS_STATE))
      begin
         rd_mux[`WDS_ST_RUN_BIT]   = (state_q == WD_RUN);
         rd_mux[`WDS_ST_OFF_BIT]   = (state_q == WD_OFF);
         rd_mux[`WDS_ST_FIRED_BIT] = (state_q == WD_FIRED);
         rd_mux[`WDS_ST_INIT_BIT]  = init_done_q;
      end
      else if (reg_hit(s_axi_araddr, `WDS_OFS_INT_STS))
         rd_mux[`WDS_EV_W-1:0] = int_sts_q;
      else if (reg_hit(s_axi_araddr, `WDS_OFS_INT_CLR))
         rd_mux = '0;
      else if (reg_hit(s_axi_araddr, `WDS_OFS_INT_EN))
         rd_mux[`WDS_EV_W-1:0] = int_en_q;
      else
         rd_ok = 1'b0;
   end

   // Read data registered on the address handshake
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_q <= 1'b0;
         rdata_q  <= '0;
         rresp_q  <= `WDS_RESP_OKAY;
      end
      else if (ar_fire)
      begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_mux;
         rresp_q  <= rd_ok ? `WDS_RESP_OKAY : `WDS_RESP_SLVERR;
      end
      else if (s_axi_rready)
         rvalid_q <= 1'b0;
   end

   // Counter clock enable
   wds_prescaler #(
      .DIV_W    (7),
      .DIV_FAST (`WDS_DIV_FAST),
      .DIV_SLOW (`WDS_DIV_SLOW)
   ) u_presc (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .slow_sel (presc_sel_q),
      .tick     (tick)
   );

   // Events; a service in the overflow cycle counts as in time
   wire running = (state_q == WD_RUN);
   wire at_max  = (cnt_q == `WDS_CNT_MAX);
   assign ev.ovf     = running && tick && at_max && !instr.service;
   assign ev.srv     = instr.service;
   assign ev.dis_ign = instr.wd_disable_instr && init_done_q;
   assign ev.eoi     = instr.end_init && !init_done_q;
   wire   dis_ok     = instr.wd_disable_instr && !init_done_q;

   // Counter: service reloads the upper byte, clears the lower one
   // Full range /2 is 5.24 ms, reload FF at /2 is 20 us, 0 at /128 is
   // 336 ms, all at a 25 MHz system clock
   always_comb
   begin
      cnt_d = cnt_q;
      if (instr.service)
         cnt_d = {reload_q, `WDS_LOW_CLEAR};
      else if (running && tick)
         cnt_d = cnt_q + 1'b1;
   end

   // Watchdog state; only a chip reset brings it back to running
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         WD_RUN:
         begin
            if (ev.ovf)
               state_d = WD_FIRED;
            else if (dis_ok)
               state_d = WD_OFF;
         end
         WD_OFF:   state_d = WD_OFF;
         WD_FIRED: state_d = WD_FIRED;
         default:  state_d = WD_RUN;
      endcase
   end

   // Core registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_q     <= WD_RUN;
         cnt_q       <= `WDS_CNT_RST;
         init_done_q <= 1'b0;
      end
      else
      begin
         state_q     <= state_d;
         cnt_q       <= cnt_d;
         init_done_q <= init_done_q || instr.end_init;
      end
   end

   // Reset pin held low from reset until end of init, and again on overflow
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_low_q <= 1'b1;
         rst_req_q <= 1'b0;
      end
      else
      begin
         if (ev.ovf)
            pin_low_q <= 1'b1;
         else if (ev.eoi)
            pin_low_q <= 1'b0;
         if (ev.ovf)
            rst_req_q <= 1'b1;
      end
   end
   assign reset_output_pin_n = !pin_low_q;
   assign wd_reset_req       = rst_req_q;

   // Sticky status; a new event beats a clear in the same cycle
   assign int_sts_d = (int_sts_q & ~clr_bits) | ev;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         int_sts_q <= '0;
      else
         int_sts_q <= int_sts_d;
   end
   assign irq = |(int_sts_q & int_en_q);

endmodule

// >>> rtl/wds_defines.svh
// Offsets, field positions, reset values and counts of the watchdog supervisor
`ifndef WDS_DEFINES_SVH
`define WDS_DEFINES_SVH
// Register byte offsets on the AXI4-Lite port
`define WDS_ADDR_W          8
`define WDS_OFS_CTRL        8'h00
`define WDS_OFS_COUNT       8'h04
`define WDS_OFS_STATE       8'h08
`define WDS_OFS_INT_STS     8'h0C
`define WDS_OFS_INT_CLR     8'h10
`define WDS_OFS_INT_EN      8'h14
// Control register fields and reset values
`define WDS_CTRL_PRESC_BIT  0
`define WDS_CTRL_RELOAD_LSB 8
`define WDS_CTRL_RELOAD_MSB 15
`define WDS_PRESC_RST       1'b0
`define WDS_RELOAD_RST      8'h00
// State register fields
`define WDS_ST_RUN_BIT      0
`define WDS_ST_OFF_BIT      1
`define WDS_ST_FIRED_BIT    2
`define WDS_ST_INIT_BIT     3
// Event bit positions in status, clear and enable registers
`define WDS_EV_W            4
`define WDS_EV_OVF          0
`define WDS_EV_SRV          1
`define WDS_EV_DIS_IGN      2
`define WDS_EV_EOI          3
// Prescaler ratios and counter limits
`define WDS_DIV_FAST        2
`define WDS_DIV_SLOW        128
`define WDS_CNT_W           16
`define WDS_CNT_MAX         16'hFFFF
`define WDS_CNT_RST         16'h0000
`define WDS_LOW_CLEAR       8'h00
// AXI responses
`define WDS_RESP_OKAY       2'h0
`define WDS_RESP_SLVERR     2'h2
`endif

// >>> rtl/wds_pkg.sv
// Types shared by the watchdog supervisor modules
package wds_pkg;
   // Instruction strobes from the CPU core, one cycle each
   typedef struct packed {
      logic service;
      logic wd_disable_instr;
      logic end_init;
   } wds_instr_s;

   // Event vector, ovf in bit 0
   typedef struct packed {
      logic eoi;
      logic dis_ign;
      logic srv;
      logic ovf;
   } wds_ev_s;

   // Watchdog states, one bit away from run on both exits
   typedef enum logic [1:0] {
      WD_RUN   = 2'h0,
      WD_OFF   = 2'h1,
      WD_FIRED = 2'h2
   } wds_state_e;
endpackage

// >>> rtl/wds_prescaler.sv
// Selectable divide-by-2 or divide-by-128 tick generator
`timescale 1ns/1ns
`include "wds_defines.svh"
module wds_prescaler import wds_pkg::*;
#(
   parameter int unsigned DIV_W    = 7,
   parameter int unsigned DIV_FAST = `WDS_DIV_FAST,
   parameter int unsigned DIV_SLOW = `WDS_DIV_SLOW
)
(
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Ratio select and output enable pulse
   input  wire logic slow_sel,
   output logic      tick
);
   logic [DIV_W-1:0] cnt_q;
   logic [DIV_W-1:0] cnt_d;
   wire  [DIV_W-1:0] last_val;
   wire              wrap;

   // Compare with >= so a ratio change mid-count never skips the wrap
   assign last_val = slow_sel ? DIV_W'(DIV_SLOW - 1) : DIV_W'(DIV_FAST - 1);
   assign wrap     = (cnt_q >= last_val);
   assign cnt_d    = wrap ? '0 : cnt_q + 1'b1;
   assign tick     = wrap;

   // Free-running divider
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end
endmodule

// >>> sim/wds_cpu_model.sv
// CPU core model that issues watchdog instruction strobes
`timescale 1ns/1ns
module wds_cpu_model import wds_pkg::*;
(
   // Clock
   input  wire logic aclk,
   // One-cycle instruction strobes
   output wds_instr_s instr
);
   initial instr = '0;

   // Waits gap + 1 cycles, then issues one instruction; one-hot k keeps the strobe legal
   task automatic issue(input logic [2:0] k, input int gap);
      repeat (gap + 1) @(posedge aclk);
      instr <= wds_instr_s'(k);
      @(posedge aclk);
      instr <= '0;
   endtask
endmodule

// >>> sim/wds_properties.sv
// Port-level assertions for the watchdog supervisor
`timescale 1ns/1ns
module wds_properties import wds_pkg::*;
(
   // Clock and reset
   input wire logic  aclk,
   input wire logic  aresetn,
   // Instruction strobes and reset outputs
   input wds_instr_s instr,
   input wire logic  wd_reset_req,
   input wire logic  reset_output_pin_n,
   // Bus handshakes
   input wire logic  s_axi_awready,
   input wire logic  s_axi_bvalid,
   input wire logic  s_axi_bready,
   input wire logic  s_axi_rvalid,
   input wire logic  s_axi_rready
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // A fire shows on both reset outputs in the same cycle
   sequence s_fire;
      $rose(wd_reset_req) ##0 !reset_output_pin_n;
   endsequence

   a_clean_start: assert property ($rose(aresetn) |-> !wd_reset_req && !reset_output_pin_n)
      else $error("reset outputs wrong after reset");
   a_fire_both: assert property ($rose(wd_reset_req) |-> s_fire)
      else $error("pin not low on fire");
   a_fire_sticky: assert property (wd_reset_req |=> wd_reset_req)
      else $error("reset request dropped");
   a_eoi_release: assert property (instr[0] && !wd_reset_req |=> reset_output_pin_n)
      else $error("pin not released by end of init");
   a_pin_held: assert property (!reset_output_pin_n && !instr[0] |=> !reset_output_pin_n)
      else $error("pin rose without end of init");
   a_service_wins: assert property (instr[2] && !wd_reset_req |=> !wd_reset_req)
      else $error("fired on a service");
   a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped early");
   a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("rvalid dropped early");
   a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("address taken during response");
   a_bresp_retire: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("bvalid kept after handshake");
   a_rdata_retire: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("rvalid kept after handshake");
endmodule

bind wds_top wds_properties chk_i (.aclk(aclk), .aresetn(aresetn), .instr(instr),
   .wd_reset_req(wd_reset_req), .reset_output_pin_n(reset_output_pin_n),
   .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// >>> sim/watchdog_supervisor_tb_top.sv
// Self-checking bench for the watchdog supervisor
`timescale 1ns/1ns
module watchdog_supervisor_tb_top import wds_pkg::*;
;
   localparam logic [2:0] SRV = 3'h4;
   localparam logic [2:0] DIS = 3'h2;
   localparam logic [2:0] EOI = 3'h1;
   // Bench-driven inputs, all defined at time zero
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, d, c1;
   // Design outputs
   logic        awready, wready, bvalid, arready, rvalid, wd_reset_req, pin_n, irq;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   wds_instr_s  instr;
   int          n_mismatch = 0, tests_run = 0;

   always #10 aclk = ~aclk;

   wds_cpu_model cpu (.aclk(aclk), .instr(instr));
   wds_top uut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .instr(instr), .wd_reset_req(wd_reset_req), .reset_output_pin_n(pin_n), .irq(irq));

   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // A handshake that never came ends the run
   task automatic bound(input int n);
      if (n >= 50)
      begin
         n_mismatch++;
         complete_run();
      end
   endtask

   // Response ready stands from the request until the answer is sampled
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50 && bvalid !== 1'b1; n++)
      begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      bound(n);
      chk(32'(bresp), 32'(er));
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50 && rvalid !== 1'b1; n++)
      begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end
      v = rdata;
      rready <= 1'b0;
      bound(n);
      chk(32'(rresp), 32'(er));
   endtask

   task automatic do_reset();
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
   endtask

   // Cycles from a service to the fire must fall in the window
   task automatic wait_fire(input int lo, input int hi);
      int n;
      for (n = 0; n < hi + 9 && wd_reset_req !== 1'b1; n++) @(posedge aclk);
      chk(32'(n >= lo && n <= hi), 32'h1);
      if (n > hi) complete_run();
   endtask

   initial
   begin
      do_reset();
      axi_rd(8'h00, d, 2'h0);
      chk(d, 32'h0);
      axi_rd(8'h08, d, 2'h0);
      chk(d, 32'h1);
      axi_rd(8'h04, c1, 2'h0);
      axi_rd(8'h04, d, 2'h0);
      chk(32'(d > c1), 32'h1);
      axi_wr(8'h00, 32'h0000AB00, 2'h0);
      cpu.issue(SRV, 0);
      axi_rd(8'h04, d, 2'h0);
      chk(32'(d[15:8]), 32'hAB);
      chk(32'(d[7:0] < 8'h10), 32'h1);
      // Slow CPU, disable still inside the start-up window
      cpu.issue(DIS, 5);
      axi_rd(8'h08, d, 2'h0);
      chk(d, 32'h2);
      axi_rd(8'h04, c1, 2'h0);
      axi_rd(8'h04, d, 2'h0);
      chk(d, c1);
      do_reset();
      cpu.issue(EOI, 0);
      @(posedge aclk);
      chk(32'(pin_n), 32'h1);
      cpu.issue(DIS, 0);
      axi_rd(8'h08, d, 2'h0);
      chk(d, 32'h9);
      axi_rd(8'h0C, d, 2'h0);
      chk(d, 32'hC);
      axi_wr(8'h14, 32'h4, 2'h0);
      chk(32'(irq), 32'h1);
      axi_wr(8'h14, 32'h0, 2'h0);
      chk(32'(irq), 32'h0);
      axi_wr(8'h14, 32'h4, 2'h0);
      axi_wr(8'h10, 32'h4, 2'h0);
      chk(32'(irq), 32'h0);
      axi_wr(8'h00, 32'h0000FF01, 2'h0);
      cpu.issue(SRV, 0);
      wait_fire(32640, 32772);
      chk(32'(pin_n), 32'h0);
      axi_rd(8'h08, d, 2'h0);
      chk(32'(d[2]), 32'h1);
      do_reset();
      axi_wr(8'h00, 32'h0000FF00, 2'h0);
      cpu.issue(SRV, 0);
      wait_fire(508, 516);
      axi_rd(8'h0C, d, 2'h0);
      chk(32'(d[0]), 32'h1);
      axi_rd(8'h40, d, 2'h2);
      chk(d, 32'h0);
      axi_wr(8'h40, 32'h1, 2'h2);
      complete_run();
   end
endmodule
